// *** pkg/cfg_regs_pkg.sv ***
// package: offsets, fields, reset values and carriers of the configuration slice
package cfg_regs_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] PERF_CTRL_OFFSET = 8'h20;
  localparam logic [7:0] CFG_SEVEN_OFFSET = 8'heb;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'hf0;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'hf1;
  localparam logic [7:0] REGION_SER_OFFSET = 8'hf2;
  localparam logic [7:0] ID_OFFSET = 8'hf3;
  localparam int NMI_BIT = 2;
  localparam int SIMD_BIT = 0;
  localparam int SERIALIZE_BIT = 7;
  localparam logic [7:0] CFG_SEVEN_MASK = 8'h05;
  localparam logic [7:0] PERF_CTRL_MASK = 8'h80;
  localparam logic [7:0] CFG_SEVEN_RESET = 8'h00;
  localparam logic [7:0] PERF_CTRL_RESET = 8'h00;
  localparam logic [2:0] REGION_SER_RESET = 3'h0;
  localparam int IRQ_NMI_BIT = 0;
  localparam int IRQ_W = 1;
  // legacy window 640 KB up to 1 MB, and the 1 GByte boundary
  localparam logic [31:0] LEGACY_LO = 32'h000a_0000;
  localparam logic [31:0] LEGACY_HI = 32'h0010_0000;
  localparam logic [31:0] GIG_BASE = 32'h4000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [1:0] region;
  } mem_req_t;
endpackage : cfg_regs_pkg

// *** design/serialize_decide.sv ***
// decides whether one memory access must keep program order
`timescale 1ns/1ps
`default_nettype none
module serialize_decide
  import cfg_regs_pkg::*;
(
  input wire mem_req_t req,
  input wire logic global_serialize,
  input wire logic [2:0] region_serialize,
  output logic in_order
);
  logic legacy;
  logic high;
  logic [3:0] region_ext;
  // region code 3 names no field and reads the zero on top
  assign region_ext = {1'b0, region_serialize};
  assign legacy = (req.addr >= LEGACY_LO) && (req.addr < LEGACY_HI); // RULE_07
  assign high = req.addr >= GIG_BASE;
  always_comb begin
    in_order = 1'b0;
    if (req.valid) begin
      if (legacy) begin
        in_order = 1'b1; // RULE_07
      end else if (high) begin
        in_order = global_serialize | region_ext[req.region]; // RULE_06
      end else begin
        in_order = global_serialize; // RULE_04
      end
    end
  end
endmodule : serialize_decide
`default_nettype wire

// *** design/cpu_config_nmi_serialize_regs.sv ***
// configuration register slice: nmi trigger, simd enable, load/store serialize
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE_01 - a one written to bit 2 of config_control_seven raises a one-cycle nmi; a zero does nothing.
// RULE_02 - a new nmi needs a fresh zero-to-one change of that bit; software clears it in between.
// RULE_03 - bit 0 of config_control_seven drives the extended simd enable output.
// RULE_04 - bit 7 of performance_control forces every memory access into program order.
// RULE_05 - software sets the serialize bit when memory-mapped devices sit outside 640 KB to 1 MB.
// RULE_06 - accesses above 1 GByte also follow separate per-region serialize bits.
// RULE_07 - with serialize clear accesses may reorder, except the 640 KB to 1 MB window.
// RULE_08 - reserved bits of config_control_seven are ignored on write and read as zero.
module cpu_config_nmi_serialize_regs
  import cfg_regs_pkg::*;
#(
  parameter logic [7:0] ID_VALUE = 8'h5a // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire reg_req_t bus_req,
  output logic [7:0] rdata,
  input wire mem_req_t mem_req,
  output logic mem_in_order,
  output logic nmi_pulse,
  output logic extended_simd_enable,
  output logic load_store_serialize,
  output logic irq
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] cfg_seven_q;
  logic [7:0] perf_ctrl_q;
  logic [2:0] region_ser_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic nmi_q;
  logic wr_seven;
  logic wr_perf;
  logic nmi_rise;

  assign wr_seven = bus_req.wr && bus_req.addr == CFG_SEVEN_OFFSET;
  assign wr_perf = bus_req.wr && bus_req.addr == PERF_CTRL_OFFSET;
  // only a zero-to-one change of the stored bit fires
  assign nmi_rise = wr_seven && bus_req.wdata[NMI_BIT] && !cfg_seven_q[NMI_BIT]; // RULE_02

  // reserved bits are dropped as they are written
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_seven_q <= CFG_SEVEN_RESET;
    end else if (wr_seven) begin
      cfg_seven_q <= bus_req.wdata & CFG_SEVEN_MASK; // RULE_08
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      perf_ctrl_q <= PERF_CTRL_RESET;
    end else if (wr_perf) begin // RULE_04
      perf_ctrl_q <= bus_req.wdata & PERF_CTRL_MASK;
    end
  end

  // stand-ins for the per-region serialize fields above 1 GByte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      region_ser_q <= REGION_SER_RESET;
    end else if (bus_req.wr && bus_req.addr == REGION_SER_OFFSET) begin
      region_ser_q <= bus_req.wdata[2:0];
    end
  end

  // ----------------------------------------
  // nmi generation
  // ----------------------------------------
  // the pulse lasts one cycle; a held one never fires again
  // software writes zero before the next trigger
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= nmi_rise; // RULE_01
    end
  end
  assign nmi_pulse = nmi_q;

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  // bit 0 latches each nmi until software writes a one to it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_status_q <= '0;
    end else begin
      // set wins over a write-one clear
      if (bus_req.wr && bus_req.addr == IRQ_STATUS_OFFSET) begin
        irq_status_q <= irq_status_q & ~bus_req.wdata[IRQ_W-1:0];
      end
      if (nmi_q) begin
        irq_status_q[IRQ_NMI_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_mask_q <= '0;
    end else if (bus_req.wr && bus_req.addr == IRQ_MASK_OFFSET) begin
      irq_mask_q <= bus_req.wdata[IRQ_W-1:0];
    end
  end
  assign irq = |(irq_status_q & irq_mask_q);

  // ----------------------------------------
  // control outputs
  // ----------------------------------------
  assign extended_simd_enable = cfg_seven_q[SIMD_BIT]; // RULE_03
  assign load_store_serialize = perf_ctrl_q[SERIALIZE_BIT]; // RULE_04

  serialize_decide u_decide (
    .req(mem_req),
    .global_serialize(load_store_serialize),
    .region_serialize(region_ser_q),
    .in_order(mem_in_order)
  ); // RULE_06

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // unmapped addresses and idle cycles read as zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        CFG_SEVEN_OFFSET: rdata <= cfg_seven_q; // RULE_08
        PERF_CTRL_OFFSET: rdata <= perf_ctrl_q;
        REGION_SER_OFFSET: rdata <= {5'h0, region_ser_q};
        IRQ_STATUS_OFFSET: rdata <= {{(8-IRQ_W){1'b0}}, irq_status_q};
        IRQ_MASK_OFFSET: rdata <= {{(8-IRQ_W){1'b0}}, irq_mask_q};
        ID_OFFSET: rdata <= ID_VALUE;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // checks: nmi trigger
  // ----------------------------------------
  // a fresh zero-to-one write of the trigger bit
  sequence nmi_fire_s;
    wr_seven && bus_req.wdata[NMI_BIT] && !cfg_seven_q[NMI_BIT];
  endsequence
  // exactly one cycle of pulse, then quiet
  sequence nmi_single_s;
    nmi_pulse ##1 !nmi_pulse;
  endsequence
  // any write of performance_control
  sequence perf_write_s;
    wr_perf;
  endsequence

  nmi_once_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
    nmi_fire_s |=> nmi_single_s) else $error("nmi pulse wrong");
  nmi_cause_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
    nmi_pulse |-> $past(wr_seven) && $past(bus_req.wdata[NMI_BIT])) else $error("nmi without write");

  // ----------------------------------------
  // checks: interrupt, nmi, simd enable, reserved bits and ordering
  // ----------------------------------------
  status_set_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
    nmi_pulse |=> irq_status_q[IRQ_NMI_BIT]) else $error("nmi event lost");
  irq_masked_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
    !irq_mask_q[IRQ_NMI_BIT] |-> !irq) else $error("masked interrupt raised");
  nmi_fresh_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_02
    (wr_seven && $past(cfg_seven_q[NMI_BIT]) && cfg_seven_q[NMI_BIT]) |=> !nmi_pulse)
    else $error("nmi without fresh edge");
  nmi_zero_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
    (wr_seven && !bus_req.wdata[NMI_BIT]) |=> !nmi_pulse) else $error("zero raised nmi");
  simd_follow_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_03
    wr_seven |=> extended_simd_enable == $past(bus_req.wdata[SIMD_BIT]))
    else $error("simd enable mismatch");
  serial_all_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_04
    (load_store_serialize && mem_req.valid) |-> mem_in_order) else $error("reorder allowed");
  legacy_order_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
    (mem_req.valid && mem_req.addr >= LEGACY_LO && mem_req.addr < LEGACY_HI) |-> mem_in_order)
    else $error("legacy window reordered");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_08
    (bus_req.rd && bus_req.addr == CFG_SEVEN_OFFSET) |=> (rdata & ~CFG_SEVEN_MASK) == 8'h00)
    else $error("reserved bits read back");
  region_high_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_06
    (mem_req.valid && mem_req.addr >= GIG_BASE && mem_req.region == 2'd0 && region_ser_q[0])
    |-> mem_in_order) else $error("region serialize ignored");

  // ----------------------------------------
  // checks: serialize and ordering
  // ----------------------------------------
  serial_follow_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_04
    perf_write_s |=> load_store_serialize == $past(bus_req.wdata[SERIALIZE_BIT]))
    else $error("serialize bit mismatch");
  perf_reserved_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_04
    (bus_req.rd && bus_req.addr == PERF_CTRL_OFFSET) |=> (rdata & ~PERF_CTRL_MASK) == 8'h00)
    else $error("performance reserved bits read back");
  idle_order_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
    !mem_req.valid |-> !mem_in_order) else $error("order forced without access");
  reorder_free_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
    (mem_req.valid && !load_store_serialize && (mem_req.addr < LEGACY_LO
    || (mem_req.addr >= LEGACY_HI && mem_req.addr < GIG_BASE))) |-> !mem_in_order)
    else $error("reorder blocked");
  // per-region serialize above 1 GByte, one pair of checks per field
  for (genvar g = 0; g < 3; g++) begin : g_region
    region_each_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_06
      (mem_req.valid && mem_req.addr >= GIG_BASE && mem_req.region == 2'(g)
      && region_ser_q[g]) |-> mem_in_order) else $error("region serialize ignored");
    region_skip_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_06
      (mem_req.valid && mem_req.addr >= GIG_BASE && mem_req.region == 2'(g)
      && !region_ser_q[g] && !load_store_serialize) |-> !mem_in_order)
      else $error("region reorder blocked");
  end
  region_none_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE_06
    (mem_req.valid && mem_req.addr >= GIG_BASE && mem_req.region == 2'h3
    && !load_store_serialize) |-> !mem_in_order) else $error("unnamed region serialized");
endmodule : cpu_config_nmi_serialize_regs
`default_nettype wire

// *** testbench/cpu_config_nmi_serialize_regs_test.sv ***
// testbench: config slice registers, nmi trigger, interrupt and access ordering
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module cpu_config_nmi_serialize_regs_test;
  import cfg_regs_pkg::*;
  logic ref_clk, rst, mem_in_order, nmi_pulse, extended_simd_enable, load_store_serialize, irq;
  reg_req_t bus_req;
  mem_req_t mem_req, m;
  logic [7:0] rdata, v, r;
  logic [2:0] rs;
  logic ser, p;
  int mismatches = 0;
  int checks = 0;
  cpu_config_nmi_serialize_regs dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
    .rdata(rdata), .mem_req(mem_req), .mem_in_order(mem_in_order), .nmi_pulse(nmi_pulse),
    .extended_simd_enable(extended_simd_enable), .load_store_serialize(load_store_serialize),
    .irq(irq));
  // ----------------------------------------
  // expectation and bus tasks
  // ----------------------------------------
  function automatic logic exp_order(mem_req_t q, logic s, logic [2:0] g);
    if (!q.valid) return 1'b0;
    if (s || (q.addr >= LEGACY_LO && q.addr < LEGACY_HI)) return 1'b1;
    return q.addr >= GIG_BASE && q.region != 2'h3 && g[q.region];
  endfunction : exp_order
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  task automatic stop_test();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    mismatches++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    bus_req = '0;
    mem_req = '0;
    p = 1'b0;
    void'($urandom(32'h845d));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(CFG_SEVEN_OFFSET, r); `CHK(r, CFG_SEVEN_RESET)
    rd(PERF_CTRL_OFFSET, r); `CHK(r, PERF_CTRL_RESET)
    `CHK({nmi_pulse, extended_simd_enable, load_store_serialize, irq}, 4'h0)
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 8'h04 : (i == 1) ? 8'hff : (i == 2) ? 8'hfa : (i == 3) ? 8'h05 : 8'($urandom);
      wr(CFG_SEVEN_OFFSET, v);
      `CHK(nmi_pulse, v[NMI_BIT] & ~p)
      p = v[NMI_BIT];
      `CHK(irq, 1'b0)
      rd(CFG_SEVEN_OFFSET, r); `CHK(r, v & CFG_SEVEN_MASK)
      `CHK(extended_simd_enable, v[SIMD_BIT])
    end
    wr(CFG_SEVEN_OFFSET, 8'h00);
    wr(CFG_SEVEN_OFFSET, 8'h04); `CHK(nmi_pulse, 1'b1)
    rd(IRQ_STATUS_OFFSET, r); `CHK(r, 8'h01)
    wr(IRQ_MASK_OFFSET, 8'h01); `CHK(irq, 1'b1)
    wr(IRQ_STATUS_OFFSET, 8'h00); `CHK(irq, 1'b1)
    wr(IRQ_STATUS_OFFSET, 8'h01); `CHK(irq, 1'b0)
    rd(IRQ_STATUS_OFFSET, r); `CHK(r, 8'h00)
    wr(8'h10, 8'($urandom));
    rd(8'h10, r); `CHK(r, 8'h00)
    for (int i = 0; i < 48; i++) begin
      if (i % 8 == 0) begin
        v = (i == 0) ? 8'h7f : $urandom;
        wr(PERF_CTRL_OFFSET, v);
        ser = v[SERIALIZE_BIT];
        rd(PERF_CTRL_OFFSET, r); `CHK(r, v & PERF_CTRL_MASK)
        `CHK(load_store_serialize, ser)
        rs = 3'($urandom);
        wr(REGION_SER_OFFSET, {5'h00, rs});
        rd(REGION_SER_OFFSET, r); `CHK(r, {5'h00, rs})
      end
      m.valid = (i % 5 != 4);
      m.region = 2'($urandom);
      case ($urandom_range(3))
        0: m.addr = $urandom;
        1: m.addr = LEGACY_LO + $urandom_range(32'h0005_ffff);
        2: m.addr = GIG_BASE + $urandom_range(32'hbfff_ffff);
        default: m.addr = ($urandom_range(1) == 1) ? LEGACY_HI - i % 2 : GIG_BASE - i % 2;
      endcase
      @(posedge ref_clk);
      mem_req <= m;
      #1;
      `CHK(mem_in_order, exp_order(m, ser, rs))
    end
    wr(PERF_CTRL_OFFSET, 8'h80);
    m = '{valid: 1'b1, addr: 32'h0200_0000, region: 2'h3};
    @(posedge ref_clk);
    mem_req <= m;
    #1;
    `CHK(mem_in_order, 1'b1)
    m.addr = GIG_BASE + 32'h0000_1000;
    @(posedge ref_clk);
    mem_req <= m;
    #1;
    `CHK(mem_in_order, 1'b1)
    wr(CFG_SEVEN_OFFSET, 8'h00);
    wr(CFG_SEVEN_OFFSET, 8'h05); `CHK(nmi_pulse, 1'b1)
    rd(IRQ_MASK_OFFSET, r); `CHK(r, 8'h01)
    `CHK({extended_simd_enable, load_store_serialize, irq}, 3'h7)
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(PERF_CTRL_OFFSET, r); `CHK(r, PERF_CTRL_RESET)
    `CHK({nmi_pulse, extended_simd_enable, load_store_serialize, irq}, 4'h0)
    rd(IRQ_MASK_OFFSET, r); `CHK(r, 8'h00)
    rd(CFG_SEVEN_OFFSET, r); `CHK(r, CFG_SEVEN_RESET)
    stop_test();
  end
endmodule : cpu_config_nmi_serialize_regs_test
`default_nettype wire
